/* File: design/cce_regs.vh */
`ifndef CCE_REGS_VH
`define CCE_REGS_VH
// Page-0 register addresses
`define CCE_SCI_CTRL2_ADR 8'h0F
`define CCE_SCI_STAT_ADR 8'h10
`define CCE_TIM_CTRL_ADR 8'h12
`define CCE_TIM_STAT_ADR 8'h13
// Control register reset value
`define CCE_CTRL_RESET 8'h00
// Timer status flag positions (upper five bits)
`define CCE_TIM_CAP1 7
`define CCE_TIM_CMP1 6
`define CCE_TIM_OVF 5
`define CCE_TIM_CAP2 4
`define CCE_TIM_CMP2 3
// Timer control enable positions
`define CCE_TIM_CAP_EN 7
`define CCE_TIM_CMP_EN 6
`define CCE_TIM_OVF_EN 5
// Serial status flag positions (upper five bits)
`define CCE_SCI_TXE 7
`define CCE_SCI_TXC 6
`define CCE_SCI_RXF 5
`define CCE_SCI_IDL 4
`define CCE_SCI_OVR 3
// Serial control two enable positions
`define CCE_SCI_TXE_EN 7
`define CCE_SCI_TXC_EN 6
`define CCE_SCI_RX_EN 5
`define CCE_SCI_IDL_EN 4
// Vector pair addresses, high byte first
`define CCE_VEC_RESET 16'h3FFE
`define CCE_VEC_SWI 16'h3FFC
`define CCE_VEC_EXT 16'h3FFA
`define CCE_VEC_CAP 16'h3FF8
`define CCE_VEC_CMP 16'h3FF6
`define CCE_VEC_OVF 16'h3FF4
`define CCE_VEC_SCI 16'h3FF2
`define CCE_VEC_CAN 16'h3FF0
// Stack page and pointer reset
`define CCE_SP_PAGE 10'h003
`define CCE_SP_RESET 6'h3F
// Condition flag positions and reset value
`define CCE_CC_H 4
`define CCE_CC_I 3
`define CCE_CC_N 2
`define CCE_CC_Z 1
`define CCE_CC_C 0
`define CCE_CCR_RESET 5'h08
// Branch length in bytes
`define CCE_BR_LEN 14'h0002
// Operation codes
`define CCE_OP_NOP 5'h00
`define CCE_OP_ALU_A 5'h01
`define CCE_OP_ALU_X 5'h02
`define CCE_OP_MUL 5'h03
`define CCE_OP_RSP 5'h04
`define CCE_OP_BSET 5'h05
`define CCE_OP_BCLR 5'h06
`define CCE_OP_BRBIT 5'h07
`define CCE_OP_BR 5'h08
`define CCE_OP_JMP 5'h09
`define CCE_OP_JSR 5'h0A
`define CCE_OP_RTS 5'h0B
`define CCE_OP_SWI 5'h0C
`define CCE_OP_RTI 5'h0D
`define CCE_OP_CLI 5'h0E
`define CCE_OP_SEI 5'h0F
`define CCE_OP_STOP 5'h10
`define CCE_OP_WAIT 5'h11
// Arithmetic unit functions
`define CCE_F_ADD 4'h0
`define CCE_F_ADC 4'h1
`define CCE_F_SUB 4'h2
`define CCE_F_SBC 4'h3
`define CCE_F_AND 4'h4
`define CCE_F_ORA 4'h5
`define CCE_F_EOR 4'h6
`define CCE_F_CMP 4'h7
`define CCE_F_BIT 4'h8
`define CCE_F_LSL 4'h9
`define CCE_F_LSR 4'hA
`define CCE_F_ROL 4'hB
`define CCE_F_ROR 4'hC
`define CCE_F_ASR 4'hD
`define CCE_F_LD 4'hE
`endif

/* File: design/cce_alu.v */
`timescale 1ns/100ps
`default_nettype none
`include "cce_regs.vh"
module cce_alu (
	// Operands
	input wire [7:0] a_i,
	input wire [7:0] b_i,
	input wire c_i,
	input wire [3:0] func_i,
	// Result and flag updates
	output reg [7:0] res_o,
	output reg c_o,
	output reg h_o,
	output reg wr_o,
	output reg c_upd_o,
	output reg h_upd_o
);
	reg [8:0] sum;
	reg [4:0] low;
	reg cin;

	// One combinational pass; N and Z are derived by the caller from res_o
	always @* begin
		sum = 9'h000;
		low = 5'h00;
		cin = 1'b0;
		res_o = a_i;
		c_o = c_i;
		h_o = 1'b0;
		wr_o = 1'b1;
		c_upd_o = 1'b0;
		h_upd_o = 1'b0;
		case (func_i)
			`CCE_F_ADD, `CCE_F_ADC: begin
				cin = (func_i == `CCE_F_ADC) & c_i;
				sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
				low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
				res_o = sum[7:0];
				c_o = sum[8];
				h_o = low[4];
				c_upd_o = 1'b1;
				h_upd_o = 1'b1;
			end
			`CCE_F_SUB, `CCE_F_SBC, `CCE_F_CMP: begin
				cin = (func_i == `CCE_F_SBC) & c_i;
				sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin};
				res_o = sum[7:0];
				c_o = sum[8]; // Borrow out
				c_upd_o = 1'b1;
				wr_o = (func_i != `CCE_F_CMP);
			end
			`CCE_F_AND, `CCE_F_BIT: begin
				res_o = a_i & b_i;
				wr_o = (func_i != `CCE_F_BIT);
			end
			`CCE_F_ORA: res_o = a_i | b_i;
			`CCE_F_EOR: res_o = a_i ^ b_i;
			// Shifts and rotates act on the target register
			`CCE_F_LSL: begin
				{c_o, res_o} = {a_i, 1'b0};
				c_upd_o = 1'b1;
			end
			`CCE_F_LSR: begin
				{res_o, c_o} = {1'b0, a_i};
				c_upd_o = 1'b1;
			end
			`CCE_F_ROL: begin
				{c_o, res_o} = {a_i, c_i};
				c_upd_o = 1'b1;
			end
			`CCE_F_ROR: begin
				{res_o, c_o} = {c_i, a_i};
				c_upd_o = 1'b1;
			end
			`CCE_F_ASR: begin
				{res_o, c_o} = {a_i[7], a_i};
				c_upd_o = 1'b1;
			end
			`CCE_F_LD: res_o = b_i;
			default: wr_o = 1'b0;
		endcase
	end
endmodule // cce_alu
`default_nettype wire

/* File: design/cce_irq.v */
`timescale 1ns/100ps
`default_nettype none
`include "cce_regs.vh"
module cce_irq (
	// Clock and reset
	input wire ref_clk_i,
	input wire reset_n_i,
	// Flag events, index 4..0 timer bits 7..3, index 9..5 serial bits 7..3
	input wire [9:0] set_i,
	input wire [9:0] assoc_i,
	input wire tim_acc_i,
	input wire sci_acc_i,
	// Enables
	input wire [7:0] tim_ctrl_i,
	input wire [7:0] sci_ctrl_i,
	// Status and requests
	output wire [7:0] tim_stat_o,
	output wire [7:0] sci_stat_o,
	output wire cap_req_o,
	output wire cmp_req_o,
	output wire ovf_req_o,
	output wire sci_req_o
);
	reg [9:0] flag_ff;
	reg [9:0] arm_ff;
	genvar g;

	// Per flag: status access arms, associated access clears; a new set wins
	generate
		for (g = 0; g < 10; g = g + 1) begin : g_flag
			always @(posedge ref_clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					flag_ff[g] <= 1'b0;
					arm_ff[g] <= 1'b0;
				end else if (set_i[g]) begin
					flag_ff[g] <= 1'b1;
					arm_ff[g] <= 1'b0;
				end else if (arm_ff[g] && assoc_i[g]) begin
					flag_ff[g] <= 1'b0;
					arm_ff[g] <= 1'b0;
				end else if (flag_ff[g] && ((g < 5) ? tim_acc_i : sci_acc_i)) begin
					arm_ff[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// Flags in the upper five bits, lower bits read zero
	assign tim_stat_o = {flag_ff[4:0], 3'b000};
	assign sci_stat_o = {flag_ff[9:5], 3'b000};

	// Grouped enables
	assign cap_req_o = (tim_stat_o[`CCE_TIM_CAP1] | tim_stat_o[`CCE_TIM_CAP2]) & tim_ctrl_i[`CCE_TIM_CAP_EN];
	assign cmp_req_o = (tim_stat_o[`CCE_TIM_CMP1] | tim_stat_o[`CCE_TIM_CMP2]) & tim_ctrl_i[`CCE_TIM_CMP_EN];
	assign ovf_req_o = tim_stat_o[`CCE_TIM_OVF] & tim_ctrl_i[`CCE_TIM_OVF_EN];
	// Overrun and receive-full share one enable
	assign sci_req_o = (sci_stat_o[`CCE_SCI_TXE] & sci_ctrl_i[`CCE_SCI_TXE_EN])
		| (sci_stat_o[`CCE_SCI_TXC] & sci_ctrl_i[`CCE_SCI_TXC_EN])
		| ((sci_stat_o[`CCE_SCI_RXF] | sci_stat_o[`CCE_SCI_OVR]) & sci_ctrl_i[`CCE_SCI_RX_EN])
		| (sci_stat_o[`CCE_SCI_IDL] & sci_ctrl_i[`CCE_SCI_IDL_EN]);
endmodule // cce_irq
`default_nettype wire

/* File: design/cce_core.v */
`timescale 1ns/100ps
`default_nettype none
`include "cce_regs.vh"
module cce_core (
	// Clock and reset
	input wire ref_clk_i,
	input wire reset_n_i,
	// Instruction port, held until op_done_o
	input wire op_valid_i,
	input wire [4:0] op_code_i,
	input wire [3:0] op_func_i,
	input wire [7:0] op_data_i,
	input wire [7:0] op_offs_i,
	input wire [7:0] op_addr_i,
	input wire [2:0] op_bit_i,
	input wire [1:0] op_len_i,
	input wire op_cond_i,
	input wire [13:0] op_jump_i,
	output wire op_done_o,
	// Memory port for stacking, vectors and bit writes
	output wire [15:0] mem_addr_o,
	output wire [7:0] mem_wdata_o,
	output wire mem_wr_o,
	output wire mem_rd_o,
	input wire [7:0] mem_rdata_i,
	// Page-0 peripheral register port
	input wire [7:0] reg_addr_i,
	input wire reg_rd_i,
	input wire reg_wr_i,
	input wire [7:0] reg_wdata_i,
	output wire [7:0] reg_rdata_o,
	// Peripheral flag events
	input wire [4:0] tim_set_i,
	input wire [4:0] sci_set_i,
	input wire [9:0] assoc_i,
	// External and CAN sources
	input wire ext_irq_i,
	input wire wired_or_irq_i,
	input wire can_irq_i,
	input wire can_asleep_i,
	// Control outputs to peripherals
	output wire [7:0] tim_ctrl_o,
	output wire [7:0] sci_ctrl_o,
	// Core state
	output wire [7:0] acc_o,
	output wire [7:0] idx_o,
	output wire [15:0] pc_o,
	output wire [15:0] sp_o,
	output wire [4:0] ccr_o,
	// Clock gating
	output wire cpu_clk_en_o,
	output wire timer_clk_en_o,
	output wire osc_en_o
);
	localparam S_IDLE = 3'd0;
	localparam S_PUSH = 3'd1;
	localparam S_PULL = 3'd2;
	localparam S_VEC = 3'd3;
	localparam S_VEC2 = 3'd4;
	localparam S_DRAIN = 3'd5;
	localparam S_STOP = 3'd6;
	localparam S_WAIT = 3'd7;
	// Stack byte index doubles as read destination
	localparam K_CCR = 3'd0;
	localparam K_A = 3'd1;
	localparam K_X = 3'd2;
	localparam K_HI = 3'd3;
	localparam K_LO = 3'd4;

	reg [2:0] state_ff;
	reg [7:0] acc_ff;
	reg [7:0] idx_ff;
	reg [13:0] pc_ff;
	reg [5:0] sp_ff;
	reg [4:0] ccr_ff;
	reg [2:0] cnt_ff;
	reg [2:0] last_ff;
	reg to_vec_ff;
	reg [15:0] vec_ff;
	reg [13:0] ret_pc_ff;
	reg [5:0] hi_ff;
	reg [15:0] mem_addr_ff;
	reg [7:0] mem_wdata_ff;
	reg mem_wr_ff;
	reg mem_rd_ff;
	reg [2:0] dst_ff;
	reg rd_seen_ff;
	reg [2:0] dst2_ff;
	reg [7:0] tim_ctrl_ff;
	reg [7:0] sci_ctrl_ff;
	reg [7:0] reg_rdata_ff;
	reg ext_pend_ff;
	reg op_done_ff;
	reg cpu_en_ff;
	reg tim_en_ff;
	reg osc_en_ff;
	reg [15:0] nxt_vec;
	reg [7:0] push_val;

	wire [7:0] tim_stat;
	wire [7:0] sci_stat;
	wire cap_req;
	wire cmp_req;
	wire ovf_req;
	wire sci_req;
	wire [7:0] alu_res;
	wire alu_c;
	wire alu_h;
	wire alu_wr;
	wire alu_cu;
	wire alu_hu;

	// Status access arms the clear sequence; reads and writes both count
	wire tim_acc = (reg_rd_i | reg_wr_i) && (reg_addr_i == `CCE_TIM_STAT_ADR);
	wire sci_acc = (reg_rd_i | reg_wr_i) && (reg_addr_i == `CCE_SCI_STAT_ADR);

	cce_irq u_irq (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.set_i({sci_set_i, tim_set_i}),
		.assoc_i(assoc_i),
		.tim_acc_i(tim_acc),
		.sci_acc_i(sci_acc),
		.tim_ctrl_i(tim_ctrl_ff),
		.sci_ctrl_i(sci_ctrl_ff),
		.tim_stat_o(tim_stat),
		.sci_stat_o(sci_stat),
		.cap_req_o(cap_req),
		.cmp_req_o(cmp_req),
		.ovf_req_o(ovf_req),
		.sci_req_o(sci_req)
	);

	// Shifts of the index register go through the same unit
	wire to_x = (op_code_i == `CCE_OP_ALU_X);
	cce_alu u_alu (
		.a_i(to_x ? idx_ff : acc_ff),
		.b_i(op_data_i),
		.c_i(ccr_ff[`CCE_CC_C]),
		.func_i(op_func_i),
		.res_o(alu_res),
		.c_o(alu_c),
		.h_o(alu_h),
		.wr_o(alu_wr),
		.c_upd_o(alu_cu),
		.h_upd_o(alu_hu)
	);

	// Request gathering; ext pulses are latched, wired-OR is a level
	wire ext_req = ext_pend_ff | wired_or_irq_i;
	wire mask_req = ext_req | cap_req | cmp_req | ovf_req | sci_req | can_irq_i;
	wire irq_go = mask_req & ~ccr_ff[`CCE_CC_I];
	wire ext_taken = (state_ff == S_IDLE) && irq_go && ext_req;

	// Next-instruction and branch targets
	wire [13:0] pc_seq = pc_ff + {12'h000, op_len_i};
	wire [13:0] br_base = (op_code_i == `CCE_OP_BR) ? pc_ff + `CCE_BR_LEN : pc_seq;
	wire [13:0] br_dest = br_base + {{6{op_offs_i[7]}}, op_offs_i};
	wire [7:0] bit_mask = 8'h01 << op_bit_i;
	wire bit_val = op_data_i[op_bit_i];
	wire [15:0] product = acc_ff * idx_ff;
	wire [5:0] sp_up = sp_ff + 6'h01;
	wire accept = (state_ff == S_IDLE) && op_valid_i && !irq_go && !op_done_ff;

	// Fixed priority among maskable sources
	always @* begin
		if (ext_req)
			nxt_vec = `CCE_VEC_EXT;
		else if (cap_req)
			nxt_vec = `CCE_VEC_CAP;
		else if (cmp_req)
			nxt_vec = `CCE_VEC_CMP;
		else if (ovf_req)
			nxt_vec = `CCE_VEC_OVF;
		else if (sci_req)
			nxt_vec = `CCE_VEC_SCI;
		else
			nxt_vec = `CCE_VEC_CAN;
	end

	// Stack byte by index; unused CONDITION_FLAGS_REGISTER bits stack as ones
	always @* begin
		case (cnt_ff)
			K_LO: push_val = ret_pc_ff[7:0];
			K_HI: push_val = {2'b00, ret_pc_ff[13:8]};
			K_X: push_val = idx_ff;
			K_A: push_val = acc_ff;
			default: push_val = {3'b111, ccr_ff};
		endcase
	end

	// External pulse latch; a new pulse beats the clear at entry
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			ext_pend_ff <= 1'b0;
		else
			ext_pend_ff <= ext_irq_i | (ext_pend_ff & ~ext_taken);
	end

	// Peripheral control registers and read-back; unmapped reads give zero
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tim_ctrl_ff <= `CCE_CTRL_RESET;
			sci_ctrl_ff <= `CCE_CTRL_RESET;
			reg_rdata_ff <= 8'h00;
		end else begin
			if (reg_wr_i && reg_addr_i == `CCE_TIM_CTRL_ADR)
				tim_ctrl_ff <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == `CCE_SCI_CTRL2_ADR)
				sci_ctrl_ff <= reg_wdata_i;
			if (reg_rd_i) begin
				case (reg_addr_i)
					`CCE_SCI_CTRL2_ADR: reg_rdata_ff <= sci_ctrl_ff;
					`CCE_SCI_STAT_ADR: reg_rdata_ff <= sci_stat;
					`CCE_TIM_CTRL_ADR: reg_rdata_ff <= tim_ctrl_ff;
					`CCE_TIM_STAT_ADR: reg_rdata_ff <= tim_stat;
					default: reg_rdata_ff <= 8'h00;
				endcase
			end
		end
	end

	// Sequencer: reset starts at the vector fetch with the mask set
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= S_VEC;
			vec_ff <= `CCE_VEC_RESET;
			ccr_ff <= `CCE_CCR_RESET;
			sp_ff <= `CCE_SP_RESET;
			acc_ff <= 8'h00;
			idx_ff <= 8'h00;
			pc_ff <= 14'h0000;
			cnt_ff <= 3'd0;
			last_ff <= 3'd0;
			to_vec_ff <= 1'b0;
			ret_pc_ff <= 14'h0000;
			hi_ff <= 6'h00;
			mem_addr_ff <= 16'h0000;
			mem_wdata_ff <= 8'h00;
			mem_wr_ff <= 1'b0;
			mem_rd_ff <= 1'b0;
			dst_ff <= K_CCR;
			rd_seen_ff <= 1'b0;
			dst2_ff <= K_CCR;
			op_done_ff <= 1'b0;
			cpu_en_ff <= 1'b1;
			tim_en_ff <= 1'b1;
			osc_en_ff <= 1'b1;
		end else begin
			mem_wr_ff <= 1'b0;
			mem_rd_ff <= 1'b0;
			op_done_ff <= accept;
			rd_seen_ff <= mem_rd_ff;
			dst2_ff <= dst_ff;
			case (state_ff)
				S_IDLE: begin
					if (irq_go) begin
						// Hardware entry: five bytes then vector
						ret_pc_ff <= pc_ff;
						vec_ff <= nxt_vec;
						cnt_ff <= K_LO;
						last_ff <= K_CCR;
						to_vec_ff <= 1'b1;
						state_ff <= S_PUSH;
					end else if (accept) begin
						pc_ff <= pc_seq;
						case (op_code_i)
							`CCE_OP_ALU_A, `CCE_OP_ALU_X: begin
								if (alu_wr && to_x)
									idx_ff <= alu_res;
								if (alu_wr && !to_x)
									acc_ff <= alu_res;
								ccr_ff[`CCE_CC_N] <= alu_res[7];
								ccr_ff[`CCE_CC_Z] <= (alu_res == 8'h00);
								if (alu_cu)
									ccr_ff[`CCE_CC_C] <= alu_c;
								if (alu_hu)
									ccr_ff[`CCE_CC_H] <= alu_h;
							end
							`CCE_OP_MUL: begin
								idx_ff <= product[15:8];
								acc_ff <= product[7:0];
								ccr_ff[`CCE_CC_H] <= 1'b0;
								ccr_ff[`CCE_CC_C] <= 1'b0;
							end
							`CCE_OP_RSP: sp_ff <= `CCE_SP_RESET;
							`CCE_OP_BSET, `CCE_OP_BCLR: begin
								// Single write of one page-0 byte; the old value comes in on op_data_i, no read
								mem_wr_ff <= 1'b1;
								mem_addr_ff <= {8'h00, op_addr_i};
								if (op_code_i == `CCE_OP_BSET)
									mem_wdata_ff <= op_data_i | bit_mask;
								else
									mem_wdata_ff <= op_data_i & ~bit_mask;
							end
							`CCE_OP_BRBIT: begin
								ccr_ff[`CCE_CC_C] <= bit_val;
								if (bit_val == op_cond_i)
									pc_ff <= br_dest;
							end
							// Two-byte branch, else falls through
							`CCE_OP_BR: pc_ff <= op_cond_i ? br_dest : pc_ff + `CCE_BR_LEN;
							`CCE_OP_JMP: pc_ff <= op_jump_i;
							`CCE_OP_JSR: begin
								ret_pc_ff <= pc_seq;
								pc_ff <= op_jump_i;
								cnt_ff <= K_LO;
								last_ff <= K_HI; // Two bytes
								to_vec_ff <= 1'b0;
								state_ff <= S_PUSH;
							end
							`CCE_OP_RTS: begin
								cnt_ff <= K_HI;
								last_ff <= K_LO;
								state_ff <= S_PULL;
							end
							`CCE_OP_RTI: begin
								cnt_ff <= K_CCR;
								last_ff <= K_LO;
								state_ff <= S_PULL;
							end
							`CCE_OP_SWI: begin
								// Not maskable, taken only after pending ones
								ret_pc_ff <= pc_seq;
								vec_ff <= `CCE_VEC_SWI;
								cnt_ff <= K_LO;
								last_ff <= K_CCR;
								to_vec_ff <= 1'b1;
								state_ff <= S_PUSH;
							end
							`CCE_OP_CLI: ccr_ff[`CCE_CC_I] <= 1'b0;
							`CCE_OP_SEI: ccr_ff[`CCE_CC_I] <= 1'b1;
							`CCE_OP_STOP: begin
								// Oscillator stays up while CAN is awake
								ccr_ff[`CCE_CC_I] <= 1'b0;
								cpu_en_ff <= 1'b0;
								tim_en_ff <= 1'b0;
								osc_en_ff <= ~can_asleep_i;
								state_ff <= S_STOP;
							end
							`CCE_OP_WAIT: begin
								ccr_ff[`CCE_CC_I] <= 1'b0;
								cpu_en_ff <= 1'b0; // Timer clock keeps running
								state_ff <= S_WAIT;
							end
							default: ;
						endcase
					end
				end
				S_PUSH: begin
					// Write then decrement, six bits wrap in the stack page
					mem_wr_ff <= 1'b1;
					mem_addr_ff <= {`CCE_SP_PAGE, sp_ff};
					mem_wdata_ff <= push_val;
					sp_ff <= sp_ff - 6'h01;
					if (cnt_ff == last_ff)
						state_ff <= to_vec_ff ? S_VEC : S_IDLE;
					else
						cnt_ff <= cnt_ff - 3'd1;
				end
				S_PULL: begin
					// Increment then read, CONDITION_FLAGS_REGISTER first on return
					sp_ff <= sp_up;
					mem_rd_ff <= 1'b1;
					mem_addr_ff <= {`CCE_SP_PAGE, sp_up};
					dst_ff <= cnt_ff;
					if (cnt_ff == last_ff)
						state_ff <= S_DRAIN;
					else
						cnt_ff <= cnt_ff + 3'd1;
				end
				S_VEC: begin
					ccr_ff[`CCE_CC_I] <= 1'b1;
					mem_rd_ff <= 1'b1;
					mem_addr_ff <= vec_ff;
					dst_ff <= K_HI;
					state_ff <= S_VEC2;
				end
				S_VEC2: begin
					mem_rd_ff <= 1'b1;
					mem_addr_ff <= {vec_ff[15:1], 1'b1};
					dst_ff <= K_LO;
					state_ff <= S_DRAIN;
				end
				S_DRAIN: begin
					if (!mem_rd_ff && !rd_seen_ff)
						state_ff <= S_IDLE;
				end
				S_STOP: begin
					if (ext_req || can_irq_i) begin
						cpu_en_ff <= 1'b1;
						tim_en_ff <= 1'b1;
						osc_en_ff <= 1'b1;
						state_ff <= S_IDLE;
					end
				end
				S_WAIT: begin
					// Wake leads to the normal vectors through S_IDLE
					if (ext_req || cap_req || cmp_req || ovf_req || sci_req) begin
						cpu_en_ff <= 1'b1;
						state_ff <= S_IDLE;
					end
				end
				default: state_ff <= S_IDLE;
			endcase
			// Read data arrives the cycle after the strobe
			if (rd_seen_ff) begin
				case (dst2_ff)
					K_CCR: ccr_ff <= mem_rdata_i[4:0];
					K_A: acc_ff <= mem_rdata_i;
					K_X: idx_ff <= mem_rdata_i;
					K_HI: hi_ff <= mem_rdata_i[5:0];
					K_LO: pc_ff <= {hi_ff, mem_rdata_i};
					default: ;
				endcase
			end
		end
	end

	// Outputs, all from flip-flops; PC top bits fixed at zero
	assign op_done_o = op_done_ff;
	assign mem_addr_o = mem_addr_ff;
	assign mem_wdata_o = mem_wdata_ff;
	assign mem_wr_o = mem_wr_ff;
	assign mem_rd_o = mem_rd_ff;
	assign reg_rdata_o = reg_rdata_ff;
	assign tim_ctrl_o = tim_ctrl_ff;
	assign sci_ctrl_o = sci_ctrl_ff;
	assign acc_o = acc_ff;
	assign idx_o = idx_ff;
	assign pc_o = {2'b00, pc_ff};
	assign sp_o = {`CCE_SP_PAGE, sp_ff};
	assign ccr_o = ccr_ff;
	assign cpu_clk_en_o = cpu_en_ff;
	assign timer_clk_en_o = tim_en_ff;
	assign osc_en_o = osc_en_ff;
endmodule // cce_core
`default_nettype wire

/* File: tb/cce_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cce_mem_model (
	// Memory port of the core
	input wire ref_clk_i,
	input wire [15:0] mem_addr_i,
	input wire [7:0] mem_wdata_i,
	input wire mem_wr_i,
	input wire mem_rd_i,
	output reg [7:0] mem_rdata_o
);
	reg [7:0] m [0:16383];
	// Vectors: reset, external, compare, overflow
	initial begin
		mem_rdata_o = 8'h00;
		m[14'h3FFE] = 8'hC1;
		m[14'h3FFF] = 8'h23;
		m[14'h3FFA] = 8'h00;
		m[14'h3FFB] = 8'h40;
		m[14'h3FF6] = 8'h00;
		m[14'h3FF7] = 8'h80;
		m[14'h3FF4] = 8'h00;
		m[14'h3FF5] = 8'h60;
	end
	// Answer one cycle late; toggles when idle so stale data is never trusted
	always @(posedge ref_clk_i) begin
		mem_rdata_o <= mem_rd_i ? m[mem_addr_i[13:0]] : ~mem_rdata_o;
		if (mem_wr_i)
			m[mem_addr_i[13:0]] <= mem_wdata_i;
	end
endmodule // cce_mem_model
`default_nettype wire

/* File: tb/cce_core_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cce_regs.vh"
module cce_core_assertions (
	// Clock, reset and op port
	input wire ref_clk_i,
	input wire reset_n_i,
	input wire [4:0] op_code_i,
	input wire [3:0] op_func_i,
	input wire [7:0] op_data_i,
	input wire op_done_o,
	// Memory port and core state
	input wire [15:0] mem_addr_o,
	input wire mem_rd_o,
	input wire mem_wr_o,
	input wire [7:0] acc_o,
	input wire [7:0] idx_o,
	input wire [15:0] pc_o,
	input wire [15:0] sp_o,
	input wire [4:0] ccr_o,
	input wire cpu_clk_en_o,
	input wire timer_clk_en_o,
	input wire osc_en_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Start vector fetched high byte first
	sequence rst_fetch_s;
		mem_rd_o && mem_addr_o == `CCE_VEC_RESET ##1 mem_rd_o && mem_addr_o == 16'h3FFF;
	endsequence
	// Odd byte read straight after the even one
	sequence vec_low_s;
		mem_rd_o && mem_addr_o == $past(mem_addr_o) + 16'h0001;
	endsequence
	reset_fetch_a: assert property ($rose(reset_n_i) |=> rst_fetch_s)
		else $error("reset vector fetch wrong");
	vec_pair_a: assert property (mem_rd_o && mem_addr_o[15:4] == 12'h3FF && !mem_addr_o[0] |=> vec_low_s)
		else $error("vector pair not read in order");
	entry_push_a: assert property (mem_rd_o && mem_addr_o == `CCE_VEC_CMP |->
		$past(mem_wr_o) && $past(mem_wr_o, 5) && ccr_o[`CCE_CC_I])
		else $error("interrupt entry stacking wrong");
	pc_top_a: assert property (pc_o[15:14] == 2'b00)
		else $error("pc top bits set");
	sp_page_a: assert property (sp_o[15:6] == `CCE_SP_PAGE)
		else $error("stack outside page");
	mul_result_a: assert property (op_done_o && $past(op_code_i) == `CCE_OP_MUL |->
		{idx_o, acc_o} == {8'h00, $past(acc_o)} * {8'h00, $past(idx_o)})
		else $error("multiply result wrong");
	add_half_a: assert property (op_done_o && $past(op_code_i) == `CCE_OP_ALU_A && $past(op_func_i) == `CCE_F_ADD |->
		ccr_o[`CCE_CC_H] == ($past(acc_o[3:0]) + $past(op_data_i[3:0]) > 5'd15)
		&& acc_o == $past(acc_o) + $past(op_data_i))
		else $error("add result or half carry wrong");
	rsp_reload_a: assert property (op_done_o && $past(op_code_i) == `CCE_OP_RSP |-> sp_o == 16'h00FF)
		else $error("stack reset wrong");
	wait_clk_a: assert property (!timer_clk_en_o |-> !cpu_clk_en_o)
		else $error("cpu clock runs with timer stopped");
	osc_off_a: assert property (!osc_en_o |-> !timer_clk_en_o)
		else $error("oscillator off outside stop");
endmodule // cce_core_assertions
bind cce_core cce_core_assertions u_cce_core_assertions (.ref_clk_i, .reset_n_i, .op_code_i, .op_func_i,
	.op_data_i, .op_done_o, .mem_addr_o, .mem_rd_o, .mem_wr_o, .acc_o, .idx_o, .pc_o, .sp_o, .ccr_o,
	.cpu_clk_en_o, .timer_clk_en_o, .osc_en_o);
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cce_regs.vh"
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_fail++; \
	$display("Error %s exp %h got %h", nm, ex, gt); end end
module tb;
	reg ref_clk_i = 0, reset_n_i = 0, vl = 0, rr = 0, rw = 0, wk = 0, slp = 0, cd = 0;
	reg [4:0] oc = 0, ts = 0, ss = 0;
	reg [3:0] of = 0;
	reg [7:0] od = 0, ra = 0, wd = 0, ofs = 0, ad = 0;
	reg [2:0] bt = 0;
	reg [13:0] jp = 0;
	reg [9:0] asc = 0;
	wire [15:0] ma, pc, sp;
	wire [7:0] mw, mr, rd, acc, idx, tc, sc;
	wire [4:0] condition_flags_register;
	wire mwr, mrd, dn, ce, te, oe;
	integer n_fail = 0, samples_checked = 0;
	cce_core u_cce_core (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .op_valid_i(vl), .op_code_i(oc),
		.op_func_i(of), .op_data_i(od), .op_offs_i(ofs), .op_addr_i(ad), .op_bit_i(bt),
		.op_len_i({1'b0, vl}), .op_cond_i(cd), .op_jump_i(jp), .op_done_o(dn), .mem_addr_o(ma),
		.mem_wdata_o(mw), .mem_wr_o(mwr), .mem_rd_o(mrd), .mem_rdata_i(mr), .reg_addr_i(ra),
		.reg_rd_i(rr), .reg_wr_i(rw), .reg_wdata_i(wd), .reg_rdata_o(rd), .tim_set_i(ts), .sci_set_i(ss),
		.assoc_i(asc), .ext_irq_i(wk), .wired_or_irq_i(wk), .can_irq_i(wk), .can_asleep_i(slp),
		.tim_ctrl_o(tc), .sci_ctrl_o(sc), .acc_o(acc), .idx_o(idx), .pc_o(pc), .sp_o(sp), .ccr_o(condition_flags_register),
		.cpu_clk_en_o(ce), .timer_clk_en_o(te), .osc_en_o(oe));
	cce_mem_model u_mem (.ref_clk_i(ref_clk_i), .mem_addr_i(ma), .mem_wdata_i(mw), .mem_wr_i(mwr),
		.mem_rd_i(mrd), .mem_rdata_o(mr));
	initial forever #5 ref_clk_i = ~ref_clk_i;
	task complete_run;
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Hold the op until the done pulse, then drop it in that cycle
	task op(input [4:0] c, input [3:0] f, input [7:0] d);
		integer i;
		oc = c;
		of = f;
		od = d;
		vl = 1;
		for (i = 0; i < 40 && dn !== 1'b1; i++)
			@(negedge ref_clk_i);
		vl = 0;
		if (i == 40)
			n_fail++;
		@(negedge ref_clk_i);
	endtask
	// One register access; read data is settled at the next falling edge
	task rg(input w, input [7:0] a, input [7:0] d);
		ra = a;
		wd = d;
		rr = !w;
		rw = w;
		@(negedge ref_clk_i);
		rr = 0;
		rw = 0;
		@(negedge ref_clk_i);
	endtask
	// Timer and serial flags are one-cycle pulses
	task pulse(input [4:0] t, input [4:0] s, input [9:0] a);
		ts = t;
		ss = s;
		asc = a;
		@(negedge ref_clk_i);
		ts = 0;
		ss = 0;
		asc = 0;
	endtask
	initial begin
		#20000;
		n_fail++;
		complete_run;
	end
	initial begin
		repeat (10) @(negedge ref_clk_i);
		reset_n_i = 1;
		repeat (8) @(negedge ref_clk_i);
		`CHK("pc", 16'h0123, pc)
		`CHK("sp", 16'h00FF, sp)
		`CHK("ccr", 5'h08, condition_flags_register)
		rg(1, `CCE_TIM_CTRL_ADR, 8'h60);
		rg(1, `CCE_SCI_CTRL2_ADR, 8'h20);
		rg(1, `CCE_TIM_STAT_ADR, 8'hFF);
		rg(0, `CCE_TIM_CTRL_ADR, 0);
		`CHK("tctl", 8'h60, rd)
		`CHK("tctl out", 8'h60, tc)
		`CHK("sctl out", 8'h20, sc)
		rg(0, `CCE_TIM_STAT_ADR, 0);
		`CHK("tstat", 8'h00, rd)
		rg(0, 8'h33, 0);
		`CHK("unmapped", 8'h00, rd)
		$display("test registers done");
		op(`CCE_OP_ALU_A, `CCE_F_LD, 8'hF8);
		op(`CCE_OP_ALU_A, `CCE_F_ADD, 8'h08);
		`CHK("acc", 8'h00, acc)
		`CHK("flags", 5'h1B, condition_flags_register)
		op(`CCE_OP_ALU_A, `CCE_F_LD, 8'h20);
		op(`CCE_OP_ALU_X, `CCE_F_LD, 8'h10);
		op(`CCE_OP_MUL, 0, 0);
		`CHK("mul", 16'h0200, {idx, acc})
		$display("test alu done");
		// Compare flag raised while masked must wait for the mask to clear
		pulse(5'h08, 0, 0);
		repeat (12) @(negedge ref_clk_i);
		`CHK("masked pc", 16'h0128, pc)
		op(`CCE_OP_CLI, 0, 0);
		repeat (14) @(negedge ref_clk_i);
		`CHK("vec pc", 16'h0080, pc)
		`CHK("entry sp", 16'h00FA, sp)
		`CHK("entry mask", 1'b1, condition_flags_register[`CCE_CC_I])
		`CHK("pushed pcl", 8'h29, u_mem.m[255])
		`CHK("pushed x", 8'h02, u_mem.m[253])
		op(`CCE_OP_RSP, 0, 0);
		`CHK("rsp", 16'h00FF, sp)
		$display("test interrupt done");
		// Flags clear only after a status access followed by the associated access
		pulse(0, 5'h04, 0);
		rg(0, `CCE_SCI_STAT_ADR, 0);
		`CHK("sstat", 8'h20, rd)
		pulse(0, 0, 10'h080);
		rg(0, `CCE_SCI_STAT_ADR, 0);
		`CHK("sclr", 8'h00, rd)
		rg(0, `CCE_TIM_STAT_ADR, 0);
		`CHK("tflag", 8'h40, rd)
		pulse(0, 0, 10'h008);
		$display("test flag clear done");
		slp = 1;
		op(`CCE_OP_STOP, 0, 0);
		repeat (3) @(negedge ref_clk_i);
		`CHK("stop clocks", 3'b000, {ce, te, oe})
		pulse(0, 0, 0);
		wk = 1;
		@(negedge ref_clk_i);
		wk = 0;
		repeat (14) @(negedge ref_clk_i);
		`CHK("stop wake", 16'h0040, pc)
		`CHK("osc", 1'b1, oe)
		op(`CCE_OP_WAIT, 0, 0);
		repeat (3) @(negedge ref_clk_i);
		`CHK("wait clocks", 2'b01, {ce, te})
		pulse(5'h04, 0, 0);
		repeat (14) @(negedge ref_clk_i);
		`CHK("wait wake", 16'h0060, pc)
		$display("test low power done");
		// Overflow flag left pending by the wake must clear before the return restores I=0
		rg(0, `CCE_TIM_STAT_ADR, 0);
		`CHK("ovf flag", 8'h20, rd)
		pulse(0, 0, 10'h004);
		rg(0, `CCE_TIM_STAT_ADR, 0);
		`CHK("tclr", 8'h00, rd)
		// Branches always advance two bytes, bit tests use the op length
		ofs = 8'h10;
		cd = 1;
		op(`CCE_OP_BR, 0, 0);
		`CHK("br taken", 16'h0072, pc)
		cd = 0;
		op(`CCE_OP_BR, 0, 0);
		`CHK("br skip", 16'h0074, pc)
		bt = 3'h2;
		cd = 1;
		op(`CCE_OP_BRBIT, 0, 8'h04);
		`CHK("brbit pc", 16'h0085, pc)
		`CHK("bit carry", 1'b1, condition_flags_register[`CCE_CC_C])
		ad = 8'h20;
		bt = 3'h3;
		op(`CCE_OP_BSET, 0, 8'h01);
		`CHK("bset", 8'h09, u_mem.m[32])
		op(`CCE_OP_BCLR, 0, 8'hFF);
		`CHK("bclr", 8'hF7, u_mem.m[32])
		// Call takes two stack bytes, return pulls them back
		jp = 14'h0200;
		op(`CCE_OP_JSR, 0, 0);
		`CHK("jsr pc", 16'h0200, pc)
		repeat (2) @(negedge ref_clk_i);
		`CHK("jsr sp", 16'h00F3, sp)
		op(`CCE_OP_RTS, 0, 0);
		repeat (6) @(negedge ref_clk_i);
		`CHK("rts pc", 16'h0088, pc)
		`CHK("rts sp", 16'h00F5, sp)
		// Return from the wait wake entry restores the stacked state
		op(`CCE_OP_ALU_A, `CCE_F_LD, 8'h55);
		op(`CCE_OP_RTI, 0, 0);
		repeat (8) @(negedge ref_clk_i);
		`CHK("rti pc", 16'h0041, pc)
		`CHK("rti acc", 8'h00, acc)
		`CHK("rti idx", 8'h02, idx)
		`CHK("rti ccr", 5'h00, condition_flags_register)
		`CHK("rti sp", 16'h00FA, sp)
		$display("test branch stack done");
		complete_run;
	end
endmodule // tb
`default_nettype wire
